// ===== rtl/steer_pkg.sv
// Purpose: shared constants and carriers for memory/io access steering
// Assumes: 32-bit classic wishbone register port, 52-bit architectural addresses
// Notes: offsets are byte addresses on the register port
package steer_pkg;
   localparam int PA_ARCH = 52;
   localparam int PAGE_LSB = 12;
   localparam int FIELD_W = PA_ARCH - PAGE_LSB;
   localparam int HI_W = PA_ARCH - 32;
   localparam int ENTRY_W = 5;
   localparam int TYPE_W = 3;
   localparam int WR_BIT = 3;
   localparam int RD_BIT = 4;
   localparam int VALID_BIT = 11;
   localparam int FIX_EN_BIT = 18;
   localparam int MOD_EN_BIT = 19;
   localparam int IO_RANGES = 2;
   localparam int ADR_W = 10;
   localparam int IO_SEL_LSB = 4;
   localparam int WORD_LSB = 2;
   localparam int ST_TYPE_LSB = 1;
   localparam int ST_SRC_LSB = 4;
   // register map
   localparam logic [ADR_W-1:0] OFS_CFG = 10'h000;
   localparam logic [ADR_W-1:0] OFS_STATUS = 10'h004;
   localparam logic [ADR_W-1:0] OFS_IO = 10'h010;
   localparam logic [ADR_W-1:0] IO_SPAN = 10'h020;
   localparam logic [ADR_W-1:0] OFS_FIX = 10'h100;
   localparam logic [3:0] SUB_BASE_LO = 4'h0;
   localparam logic [3:0] SUB_BASE_HI = 4'h4;
   localparam logic [3:0] SUB_MASK_LO = 4'h8;
   localparam logic [3:0] SUB_MASK_HI = 4'hc;
   localparam logic [ENTRY_W-1:0] STEER_BITS = 5'h18;
   // where the last access was steered from
   typedef enum logic [1:0] {
      SRC_DEFAULT = 2'b00,
      SRC_FIXED = 2'b01,
      SRC_IO0 = 2'b10,
      SRC_IO1 = 2'b11
   } src_e;
   typedef struct packed {
      logic valid;
      logic write;
      logic [PA_ARCH-1:0] addr;
      logic [TYPE_W-1:0] effType;
   } acc_req_s;
   typedef struct packed {
      logic valid;
      logic toDram;
      logic [TYPE_W-1:0] memType;
      src_e src;
   } route_s;
   typedef struct packed {
      logic [FIELD_W-1:0] rangeBaseAddr;
      logic loadToDramSelect;
      logic storeToDramSelect;
   } io_base_s;
   typedef struct packed {
      logic [FIELD_W-1:0] rangeSizeMask;
      logic valid;
   } io_mask_s;
endpackage

// ===== rtl/io_range_match.sv
// Purpose: base/mask hit test for one io route range
// Assumes: low 12 address bits never take part in the compare
// Notes: bits above PA_BITS are ignored on narrower parts
module io_range_match
   import steer_pkg::*;
#(
   parameter int PA_BITS = PA_ARCH
)
(
   input wire logic [PA_ARCH-1:0] addr,
   input io_base_s base,
   input io_mask_s mask,
   output logic hit
);
   localparam logic [FIELD_W-1:0] IMPL = {FIELD_W{1'b1}} >> (PA_ARCH - PA_BITS);

   // masked compare of the page number only
   assign hit = mask.valid
      && (((addr[PA_ARCH-1:PAGE_LSB] ^ base.rangeBaseAddr) & mask.rangeSizeMask & IMPL) == '0);
endmodule

// ===== rtl/fixed_range_index.sv
// Purpose: finds the fixed-range entry that covers an address
// Assumes: entries are equal sized granules starting at address zero
// Notes: granule size and entry count are parameters
module fixed_range_index
   import steer_pkg::*;
#(
   parameter int NUM_FIXED = 64,
   parameter int GRAN_BITS = 14,
   parameter int IDX_W = $clog2(NUM_FIXED)
)
(
   input wire logic [PA_ARCH-1:0] addr,
   output logic inFixed,
   output logic [IDX_W-1:0] idx
);
   localparam logic [PA_ARCH-GRAN_BITS-1:0] LIMIT = (PA_ARCH-GRAN_BITS)'(NUM_FIXED);

   // granule number below the entry count means covered
   assign inFixed = addr[PA_ARCH-1:GRAN_BITS] < LIMIT;
   assign idx = addr[GRAN_BITS +: IDX_W];
endmodule

// ===== rtl/memory_io_access_steering.sv
// Purpose: steers each physical access to system memory or memory-mapped io
// Assumes: access requests come from logic on clk_sys, one per cycle at most
// Notes: registers sit behind a classic wishbone slave, one answer per request
// What this block does
// - fixed entry bit 3 set sends writes to memory, clear to mmio
// - fixed entry bit 4 set sends reads to memory, clear to mmio
// - fixed entry bits 2:0 hold the type, bits 4:3 only steering
// - fixed steering honoured only while config bit 18 set, else mmio
// - config bit 19 clear: steering bits keep value on write, read zero
// - reserved steering and type pairs give undefined results
// - two independent io route ranges, each a base and mask pair
// - io range steering keeps the effective type; fixed entries supply their own type
// - base bit 3 steers writes, bit 4 steers reads, 1 means memory
// - base field bits 51:12, low twelve address bits taken as zero
// - mask field bits 51:12 sizes the range, low bits zero
// - mask bit 11 enables the pair; clear pair has no effect
// - defined base and mask fields read back; reserved bits written zero
// - io range compares use only implemented physical address bits
// - with fixed steering disabled, fixed-range accesses go to mmio even where an io range hits; io hits outside it follow their base bits
module memory_io_access_steering
   import steer_pkg::*;
#(
   parameter int NUM_FIXED = 64,
   parameter int GRAN_BITS = 14,
   parameter int PA_BITS = PA_ARCH
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [ADR_W-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   input acc_req_s accReq,
   output route_s route
);
   localparam int IDX_W = $clog2(NUM_FIXED);
   localparam logic [ADR_W-1:0] FIX_LIMIT = ADR_W'(NUM_FIXED << WORD_LSB);

   typedef struct packed {
      logic fixedSteerEnable;
      logic fixedSteerModifyEnable;
      logic [NUM_FIXED-1:0][ENTRY_W-1:0] fixTbl;
      io_base_s [IO_RANGES-1:0] ioBase;
      io_mask_s [IO_RANGES-1:0] ioMask;
      route_s route;
      logic ack;
      logic [31:0] rdData;
   } state_s;

   state_s st;
   state_s next_st;
   logic wbReq;
   logic [ADR_W-1:0] wordAdr;
   logic [ADR_W-1:0] ioOfs;
   logic [ADR_W-1:0] fixOfs;
   logic isIo;
   logic isFix;
   logic ioSel;
   logic [3:0] ioSub;
   logic [IDX_W-1:0] fixIdx;
   logic [31:0] rdWord;
   logic [31:0] merged;
   logic inFixed;
   logic [IDX_W-1:0] accIdx;
   logic [IO_RANGES-1:0] ioHit;
   logic [ENTRY_W-1:0] accEntry;
   logic [ENTRY_W-1:0] busEntry;

   // byte-lane merge of write data over the current readback
   function automatic logic [31:0] merge_lanes(
      input logic [31:0] cur,
      input logic [31:0] wd,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = cur;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // address split; request taken once, ack blocks a repeat
   assign wbReq = wbCyc && wbStb && !st.ack;
   assign wordAdr = {wbAdr[ADR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
   assign ioOfs = wordAdr - OFS_IO;
   assign fixOfs = wordAdr - OFS_FIX;
   assign isIo = (wordAdr >= OFS_IO) && (ioOfs < IO_SPAN);
   assign isFix = (wordAdr >= OFS_FIX) && (fixOfs < FIX_LIMIT);
   assign ioSel = ioOfs[IO_SEL_LSB];
   assign ioSub = ioOfs[3:0];
   assign fixIdx = fixOfs[WORD_LSB +: IDX_W];
   assign busEntry = st.fixTbl[fixIdx];
   assign accEntry = st.fixTbl[accIdx];

   fixed_range_index #(
      .NUM_FIXED(NUM_FIXED),
      .GRAN_BITS(GRAN_BITS),
      .IDX_W(IDX_W)
   ) u_fix (
      .addr(accReq.addr),
      .inFixed(inFixed),
      .idx(accIdx)
   );

   // one matcher per range; pair fields feed it straight from state
   for (genvar r = 0; r < IO_RANGES; r++)
   begin : g_io
      io_range_match #(
         .PA_BITS(PA_BITS)
      ) u_match (
         .addr(accReq.addr),
         .base(st.ioBase[r]),
         .mask(st.ioMask[r]),
         .hit(ioHit[r])
      );
   end

   // register readback; unmapped words read zero
   always_comb
   begin
      rdWord = '0;
      if (wordAdr == OFS_CFG)
      begin
         rdWord[FIX_EN_BIT] = st.fixedSteerEnable;
         rdWord[MOD_EN_BIT] = st.fixedSteerModifyEnable;
      end
      else if (wordAdr == OFS_STATUS)
      begin
         rdWord[0] = st.route.toDram;
         rdWord[ST_TYPE_LSB +: TYPE_W] = st.route.memType;
         rdWord[ST_SRC_LSB +: 2] = st.route.src;
      end
      else if (isIo && ioSub == SUB_BASE_LO)
      begin
         rdWord[31:PAGE_LSB] = st.ioBase[ioSel].rangeBaseAddr[31-PAGE_LSB:0];
         rdWord[RD_BIT] = st.ioBase[ioSel].loadToDramSelect;
         rdWord[WR_BIT] = st.ioBase[ioSel].storeToDramSelect;
      end
      else if (isIo && ioSub == SUB_BASE_HI)
      begin
         rdWord[HI_W-1:0] = st.ioBase[ioSel].rangeBaseAddr[FIELD_W-1 -: HI_W];
      end
      else if (isIo && ioSub == SUB_MASK_LO)
      begin
         rdWord[31:PAGE_LSB] = st.ioMask[ioSel].rangeSizeMask[31-PAGE_LSB:0];
         rdWord[VALID_BIT] = st.ioMask[ioSel].valid;
      end
      else if (isIo && ioSub == SUB_MASK_HI)
      begin
         rdWord[HI_W-1:0] = st.ioMask[ioSel].rangeSizeMask[FIELD_W-1 -: HI_W];
      end
      else if (isFix)
      begin
         // locked steering bits read as zero
         rdWord[ENTRY_W-1:0] = st.fixedSteerModifyEnable ? busEntry : (busEntry & ~STEER_BITS);
      end
   end

   assign merged = merge_lanes(rdWord, wbDatI, wbSel);

   // next state: bus access, then access steering
   always_comb
   begin
      next_st = st;
      next_st.ack = 1'b0;
      next_st.route.valid = 1'b0;
      if (wbReq)
      begin
         next_st.ack = 1'b1;
         next_st.rdData = rdWord;
         if (wbWe)
         begin
            if (wordAdr == OFS_CFG)
            begin
               next_st.fixedSteerEnable = merged[FIX_EN_BIT];
               next_st.fixedSteerModifyEnable = merged[MOD_EN_BIT];
            end
            else if (isIo && ioSub == SUB_BASE_LO)
            begin
               // reserved bits dropped, field kept page aligned
               next_st.ioBase[ioSel].rangeBaseAddr[31-PAGE_LSB:0] = merged[31:PAGE_LSB];
               next_st.ioBase[ioSel].loadToDramSelect = merged[RD_BIT];
               next_st.ioBase[ioSel].storeToDramSelect = merged[WR_BIT];
            end
            else if (isIo && ioSub == SUB_BASE_HI)
            begin
               next_st.ioBase[ioSel].rangeBaseAddr[FIELD_W-1 -: HI_W] = merged[HI_W-1:0];
            end
            else if (isIo && ioSub == SUB_MASK_LO)
            begin
               next_st.ioMask[ioSel].rangeSizeMask[31-PAGE_LSB:0] = merged[31:PAGE_LSB];
               next_st.ioMask[ioSel].valid = merged[VALID_BIT];
            end
            else if (isIo && ioSub == SUB_MASK_HI)
            begin
               next_st.ioMask[ioSel].rangeSizeMask[FIELD_W-1 -: HI_W] = merged[HI_W-1:0];
            end
            else if (isFix)
            begin
               // type field always writable, steering only when unlocked
               next_st.fixTbl[fixIdx][TYPE_W-1:0] = merged[TYPE_W-1:0];
               if (st.fixedSteerModifyEnable)
               begin
                  next_st.fixTbl[fixIdx][RD_BIT:WR_BIT] = merged[RD_BIT:WR_BIT];
               end
            end
         end
      end
      // reserved type pairs are passed through unchecked
      if (accReq.valid)
      begin
         next_st.route.valid = 1'b1;
         if (inFixed)
         begin
            next_st.route.src = SRC_FIXED;
            next_st.route.memType = accEntry[TYPE_W-1:0];
            next_st.route.toDram = st.fixedSteerEnable
               && (accReq.write ? accEntry[WR_BIT] : accEntry[RD_BIT]);
         end
         else if (ioHit[0])
         begin
            // range 0 wins on overlap
            next_st.route.src = SRC_IO0;
            next_st.route.memType = accReq.effType;
            next_st.route.toDram = accReq.write ? st.ioBase[0].storeToDramSelect
               : st.ioBase[0].loadToDramSelect;
         end
         else if (ioHit[1])
         begin
            next_st.route.src = SRC_IO1;
            next_st.route.memType = accReq.effType;
            next_st.route.toDram = accReq.write ? st.ioBase[1].storeToDramSelect
               : st.ioBase[1].loadToDramSelect;
         end
         else
         begin
            next_st.route.src = SRC_DEFAULT;
            next_st.route.memType = accReq.effType;
            next_st.route.toDram = 1'b0;
         end
      end
   end

   // state register; reset wins over ce, ce low freezes everything else
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign wbAck = st.ack;
   assign wbDatO = st.rdData;
   assign route = st.route;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   logic [1:0] curSteer;
   assign curSteer = busEntry[RD_BIT:WR_BIT];

   route_latency_a: assert property (ce && accReq.valid |=> route.valid)
      else $error("access got no route");
   fix_write_a: assert property (ce && accReq.valid && accReq.write && inFixed && st.fixedSteerEnable
      |=> route.toDram == $past(accEntry[WR_BIT]) && route.src == SRC_FIXED)
      else $error("fixed write steering wrong");
   fix_read_a: assert property (ce && accReq.valid && !accReq.write && inFixed && st.fixedSteerEnable
      |=> route.toDram == $past(accEntry[RD_BIT]) && route.memType == $past(accEntry[TYPE_W-1:0]))
      else $error("fixed read steering wrong");
   fix_disabled_a: assert property (ce && accReq.valid && inFixed && !st.fixedSteerEnable
      |=> !route.toDram)
      else $error("disabled fixed steer reached memory");
   io_hit_a: assert property (ce && accReq.valid && !inFixed && ioHit[0] && accReq.write
      |=> route.toDram == $past(st.ioBase[0].storeToDramSelect) && route.src == SRC_IO0)
      else $error("io range write steering wrong");
   default_mmio_a: assert property (ce && accReq.valid && !inFixed && ioHit == '0
      |=> !route.toDram && route.src == SRC_DEFAULT)
      else $error("unmatched access not sent to mmio");
   steer_lock_a: assert property (ce && wbReq && wbWe && isFix && !st.fixedSteerModifyEnable
      |=> st.fixTbl[$past(fixIdx)][RD_BIT:WR_BIT] == $past(curSteer))
      else $error("locked steering bits changed");
   lock_read_a: assert property (ce && wbReq && !wbWe && isFix && !st.fixedSteerModifyEnable
      |=> wbAck && wbDatO[RD_BIT:WR_BIT] == 2'h0)
      else $error("locked steering bits read nonzero");
   invalid_pair_a: assert property (!st.ioMask[0].valid |-> !ioHit[0])
      else $error("disabled range matched");
   reset_valid_a: assert property ($rose(rstn) |-> st.ioMask == '0)
      else $error("range valid after reset");
   ack_pulse_a: assert property (wbAck |=> !wbAck)
      else $error("ack held two cycles");
endmodule

// ===== verification/path_sink.sv
// Purpose: far-side model of the system-memory and mmio access paths
// Assumes: one routed access per route.valid pulse, clk_sys domain
// Notes: only counts arrivals; data movement is outside this block
module path_sink
   import steer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input route_s route,
   output logic [15:0] memCount,
   output logic [15:0] mmioCount
);
   // tally each access by the path it was sent down; fields are read only on the pulse
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         memCount <= 16'h0;
         mmioCount <= 16'h0;
      end
      else if (route.valid === 1'b1)
      begin
         if (route.toDram)
            memCount <= memCount + 16'h1;
         else
            mmioCount <= mmioCount + 16'h1;
      end
   end
endmodule

// ===== verification/tb.sv
// Purpose: self-checking bench for memory/io access steering
// Assumes: classic wishbone, one access per request, defaults 64 x 16 KB fixed region
// Notes: software ordering rules are kept by the stimulus itself
module tb
   import steer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [ADR_W-1:0] wbAdr = '0;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   acc_req_s accReq = '0;
   route_s route;
   logic [15:0] memCount;
   logic [15:0] mmioCount;
   logic ce = 1'b1;
   logic [3:0] wbSel = 4'hf;
   int err_total = 0;
   int n_checks = 0;
   int expMem = 0;
   int expMmio = 0;

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   memory_io_access_steering dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
      .accReq(accReq), .route(route));
   path_sink sink (.clk_sys(clk_sys), .rstn(rstn), .route(route), .memCount(memCount), .mmioCount(mmioCount));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one classic cycle; ack is read right after the edge, before the slave's update lands
   task automatic wbXfer(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wbAck !== 1'b1 && n < 50);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 50)
         chk("wbAck", 32'h1, 32'h0);
   endtask

   task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbXfer(1'b1, a, d, q);
   endtask

   task automatic rdChk(input string what, input logic [ADR_W-1:0] a, input logic [31:0] e);
      logic [31:0] q;
      wbXfer(1'b0, a, 32'h0, q);
      chk(what, e, q);
   endtask

   // one access; the route pulse is looked at in the cycle after the taking edge
   task automatic acc(input logic w, input logic [PA_ARCH-1:0] a, input logic [2:0] t, input logic dram,
      input logic [2:0] mt, input src_e s);
      route_s e;
      @(posedge clk_sys);
      accReq <= '{valid: 1'b1, write: w, addr: a, effType: t};
      @(posedge clk_sys);
      accReq.valid <= 1'b0;
      #1;
      e = '{valid: 1'b1, toDram: dram, memType: mt, src: s};
      if (dram)
         expMem++;
      else
         expMmio++;
      chk("route", {25'h0, e}, {25'h0, route});
   endtask

   task automatic resetVals();
      rdChk("cfg", OFS_CFG, 32'h0);
      rdChk("mask0 lo", 10'h018, 32'h0);
      rdChk("mask1 lo", 10'h028, 32'h0);
      acc(1'b0, 52'h2000_0000, 3'h4, 1'b0, 3'h4, SRC_DEFAULT);
      $display("test resetVals done");
   endtask

   task automatic fixedSteer();
      rdChk("entry2 locked", 10'h108, 32'h0);
      wr(10'h108, 32'h19);
      rdChk("entry2 locked", 10'h108, 32'h1);
      wr(OFS_CFG, 32'h8_0000);
      wr(10'h108, 32'h9);
      rdChk("entry2", 10'h108, 32'h9);
      acc(1'b1, 52'h8000, 3'h0, 1'b0, 3'h1, SRC_FIXED);
      wr(OFS_CFG, 32'hc_0000);
      acc(1'b1, 52'h8000, 3'h0, 1'b1, 3'h1, SRC_FIXED);
      acc(1'b0, 52'h8004, 3'h0, 1'b0, 3'h1, SRC_FIXED);
      wr(10'h108, 32'h15);
      acc(1'b1, 52'hbffc, 3'h0, 1'b0, 3'h5, SRC_FIXED);
      acc(1'b0, 52'hbffc, 3'h0, 1'b1, 3'h5, SRC_FIXED);
      wr(10'h10c, 32'h1e);
      wr(10'h110, 32'h04);
      acc(1'b0, 52'hc000, 3'h0, 1'b1, 3'h6, SRC_FIXED);
      acc(1'b1, 52'hc000, 3'h0, 1'b1, 3'h6, SRC_FIXED);
      acc(1'b0, 52'h1_0000, 3'h0, 1'b0, 3'h4, SRC_FIXED);
      wr(OFS_CFG, 32'h4_0000);
      wr(10'h108, 32'h0d);
      rdChk("entry2 hidden", 10'h108, 32'h5);
      acc(1'b0, 52'h8000, 3'h0, 1'b1, 3'h5, SRC_FIXED);
      $display("test fixedSteer done");
   endtask

   task automatic ioRanges();
      wr(10'h010, 32'h2000_0008);
      wr(10'h014, 32'h0);
      wr(10'h01c, 32'hf_ffff);
      wr(10'h018, 32'hffff_f000);
      acc(1'b1, 52'h2000_0000, 3'h1, 1'b0, 3'h1, SRC_DEFAULT);
      wr(10'h018, 32'hffff_f800);
      acc(1'b1, 52'h2000_0000, 3'h1, 1'b1, 3'h1, SRC_IO0);
      acc(1'b0, 52'h2000_0fff, 3'h0, 1'b0, 3'h0, SRC_IO0);
      acc(1'b1, 52'h2000_1000, 3'h1, 1'b0, 3'h1, SRC_DEFAULT);
      wr(10'h020, 32'h18); // range 1 kept clear of range 0
      wr(10'h024, 32'h8);
      wr(10'h02c, 32'hf_ffff);
      wr(10'h028, 32'hffff_0800);
      acc(1'b0, 52'h8_0000_f000, 3'h6, 1'b1, 3'h6, SRC_IO1);
      acc(1'b1, 52'h8_0000_0000, 3'h6, 1'b1, 3'h6, SRC_IO1);
      acc(1'b0, 52'h8_0001_0000, 3'h2, 1'b0, 3'h2, SRC_DEFAULT);
      rdChk("status", OFS_STATUS, 32'h4);
      rdChk("base1 lo", 10'h020, 32'h18);
      rdChk("base1 hi", 10'h024, 32'h8);
      rdChk("mask1 lo", 10'h028, 32'hffff_0800);
      rdChk("mask0 hi", 10'h01c, 32'hf_ffff);
      rdChk("unmapped", 10'h3f0, 32'h0);
      $display("test ioRanges done");
   endtask

   // one byte lane written alone, then a request held while ce is low must never be taken
   task automatic laneCe();
      wbSel <= 4'h2;
      wr(10'h020, 32'hffff_ffff);
      wbSel <= 4'hf;
      rdChk("base1 lane1", 10'h020, 32'h0000_f018);
      @(posedge clk_sys);
      ce <= 1'b0;
      accReq <= '{valid: 1'b1, write: 1'b0, addr: 52'h8000, effType: 3'h0};
      repeat (2) @(posedge clk_sys);
      chk("route frozen", 32'h0, {31'h0, route.valid});
      ce <= 1'b1;
      accReq.valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("route after ce", 32'h0, {31'h0, route.valid});
      $display("test laneCe done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence, reset held for four cycles first
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      resetVals();
      fixedSteer();
      ioRanges();
      laneCe();
      chk("memCount", {16'h0, expMem[15:0]}, {16'h0, memCount});
      chk("mmioCount", {16'h0, expMmio[15:0]}, {16'h0, mmioCount});
      finish_test();
   end

   // watchdog: the tests need about 140 cycles, this allows far more
   initial
   begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule
